// file: logic/htac_pkg.sv
// Package for the hardware trigger acquisition controller.
// Assumes a single 100 MHz clock domain.
package htac_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Exposure, readout and frame period are counted in time-base ticks
    localparam int TIME_BASE_NS = 1000;
    localparam int TIME_BASE_CYC = (TIME_BASE_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam int TB_W = 12;
    // Selector code for the acquisition start trigger
    localparam logic [1:0] SEL_ACQ_START = 2'h0;
    // Reset values
    localparam logic LINE_SEL_RST = 1'b0;
    localparam logic EDGE_SEL_RST = 1'b0;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ARMED = 3'b001,
        ST_EXPOSE = 3'b010,
        ST_READOUT = 3'b011,
        ST_TRANSMIT = 3'b100
    } htac_state_e;
endpackage

// file: logic/htac_ctrl.sv
// Hardware trigger acquisition controller: arms on start, accepts edges,
// times exposure, readout and transmission, drives trigger ready.
// Assumes inputs synchronous to clk and start/stop one-cycle pulses.
`timescale 1ns/1ps

// Contract
// - Trigger used only when selector and mode on
// - Source setting picks input line 1 or 2
// - Activation setting picks rising or falling edge
// - Single-frame start arms for exactly one edge
// - Timed mode: exposure lasts programmed time
// - Exposure end leads to readout then transmit
// - Single-frame ignores edges until next start
// - Continuous mode accepts every edge, no rearm; code ignores edges during a frame
// - Stop command ends trigger response until restart
// - Enabled rate limit paces accepted triggers
// - Limit above maximum capped to maximum rate
// - Reset default source is input line 1
// - Width mode: exposure ends on opposite edge
module htac_ctrl #(
    parameter int CNT_W = htac_pkg::CNT_W,
    parameter int TIME_BASE_CYC = htac_pkg::TIME_BASE_CYC
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic input_line_1,
    input wire logic input_line_2,
    input wire logic [1:0] trigger_selector,
    input wire logic trigger_mode_on,
    input wire logic trigger_source_line2,
    input wire logic trigger_activation_falling,
    input wire logic exposure_mode_width,
    input wire logic continuous_mode,
    input wire logic acquisition_start,
    input wire logic acquisition_stop,
    input wire logic [CNT_W-1:0] exposure_ticks,
    input wire logic [CNT_W-1:0] readout_ticks,
    input wire logic [CNT_W-1:0] transmit_ticks,
    input wire logic frame_rate_limit_enable,
    input wire logic [CNT_W-1:0] frame_period_ticks,
    output logic trigger_ready_output,
    output logic exposure_active,
    output logic readout_active,
    output logic transmit_active,
    output logic armed,
    output logic frame_done
);
    initial
    begin
        if (CNT_W < 2)
        begin
            $error("htac_ctrl: counter width below 2");
        end
        // Time base counter is 16 bits wide
        if (TIME_BASE_CYC < 1 || TIME_BASE_CYC > 65536)
        begin
            $error("htac_ctrl: time base out of range");
        end
    end

    // Edge detector, phase and frame-period state
    htac_pkg::htac_state_e state_r;
    logic armed_r;
    logic trig_prev_r;
    logic [15:0] tb_cnt_r;
    logic tick;
    logic [CNT_W-1:0] phase_cnt_r;
    logic [CNT_W-1:0] period_cnt_r;
    logic [CNT_W-1:0] min_period;
    logic [CNT_W-1:0] cap_period;
    logic period_ok;
    logic trig_raw;
    logic trig_lvl;
    logic active_edge;
    logic release_edge;
    logic trig_enabled;
    logic accept;
    logic frame_end;

    // Line choice; line 1 when source bit is low, its reset default
    assign trig_raw = trigger_source_line2 ? input_line_2 : input_line_1;
    // Normalise polarity so high means asserted
    assign trig_lvl = trig_raw ^ trigger_activation_falling;
    assign active_edge = trig_lvl & ~trig_prev_r;
    assign release_edge = ~trig_lvl & trig_prev_r;
    assign trig_enabled = trigger_mode_on
        && (trigger_selector == htac_pkg::SEL_ACQ_START);

    // Fastest frame the current settings allow, non-overlapped
    assign min_period = CNT_W'(exposure_ticks + readout_ticks
        + transmit_ticks);
    // Requested limit only counts when slower than the maximum
    always_comb
    begin
        cap_period = min_period;
        if (frame_rate_limit_enable && frame_period_ticks > min_period)
        begin
            cap_period = frame_period_ticks;
        end
    end
    // Period counts ticks from the last accepted edge
    assign period_ok = period_cnt_r >= cap_period;

    // Ready's terms with active_edge in place of !accept, so ready drops in the cycle an edge is taken
    assign accept = trig_enabled && armed_r && active_edge
        && (state_r == htac_pkg::ST_ARMED) && period_ok;

    // Free-running base: first tick of a phase may be short
    assign tick = (tb_cnt_r == 16'(TIME_BASE_CYC - 1));
    // Last transmit tick closes the frame
    assign frame_end = (state_r == htac_pkg::ST_TRANSMIT) && tick
        && (phase_cnt_r + 1'b1 >= transmit_ticks);

    // Reset low; ready stays low until armed, so no false accept
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_prev_r <= 1'b0;
        end
        else
        begin
            trig_prev_r <= trig_lvl;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tb_cnt_r <= 16'h0000;
        end
        else if (tick)
        begin
            tb_cnt_r <= 16'h0000;
        end
        else
        begin
            tb_cnt_r <= tb_cnt_r + 16'h0001;
        end
    end

    // Frame period counter; saturates so long idles never wrap
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            period_cnt_r <= '1;
        end
        else if (accept)
        begin
            period_cnt_r <= '0;
        end
        else if (tick && period_cnt_r != '1)
        begin
            period_cnt_r <= period_cnt_r + 1'b1;
        end
    end

    // Arm flag: start sets, stop clears, single-frame clears on accept
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            armed_r <= 1'b0;
        end
        // Stop wins over start in the same cycle
        else if (acquisition_stop)
        begin
            armed_r <= 1'b0;
        end
        else if (acquisition_start)
        begin
            armed_r <= 1'b1;
        end
        else if (accept && !continuous_mode)
        begin
            armed_r <= 1'b0;
        end
    end

    // Sequencer; a started frame always completes, even after stop
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= htac_pkg::ST_IDLE;
            phase_cnt_r <= '0;
        end
        else
        begin
            unique case (state_r)
                htac_pkg::ST_IDLE:
                begin
                    phase_cnt_r <= '0;
                    if (armed_r && !acquisition_stop)
                    begin
                        state_r <= htac_pkg::ST_ARMED;
                    end
                end
                htac_pkg::ST_ARMED:
                begin
                    phase_cnt_r <= '0;
                    if (accept)
                    begin
                        state_r <= htac_pkg::ST_EXPOSE;
                    end
                    else if (!armed_r)
                    begin
                        state_r <= htac_pkg::ST_IDLE;
                    end
                end
                htac_pkg::ST_EXPOSE:
                begin
                    if (exposure_mode_width)
                    begin
                        // Opposite edge ends exposure; time not used
                        if (release_edge)
                        begin
                            state_r <= htac_pkg::ST_READOUT;
                            phase_cnt_r <= '0;
                        end
                    end
                    // Timed: count time-base ticks of exposure
                    else if (tick)
                    begin
                        if (phase_cnt_r + 1'b1 >= exposure_ticks)
                        begin
                            state_r <= htac_pkg::ST_READOUT;
                            phase_cnt_r <= '0;
                        end
                        else
                        begin
                            phase_cnt_r <= phase_cnt_r + 1'b1;
                        end
                    end
                end
                htac_pkg::ST_READOUT:
                begin
                    // Readout never overlaps the next exposure
                    if (tick)
                    begin
                        if (phase_cnt_r + 1'b1 >= readout_ticks)
                        begin
                            state_r <= htac_pkg::ST_TRANSMIT;
                            phase_cnt_r <= '0;
                        end
                        else
                        begin
                            phase_cnt_r <= phase_cnt_r + 1'b1;
                        end
                    end
                end
                htac_pkg::ST_TRANSMIT:
                begin
                    if (frame_end)
                    begin
                        // Continuous stays armed, single-frame drops out
                        state_r <= armed_r ? htac_pkg::ST_ARMED
                            : htac_pkg::ST_IDLE;
                        phase_cnt_r <= '0;
                    end
                    else if (tick)
                    begin
                        phase_cnt_r <= phase_cnt_r + 1'b1;
                    end
                end
                default:
                begin
                    state_r <= htac_pkg::ST_IDLE;
                    phase_cnt_r <= '0;
                end
            endcase
        end
    end

    // Registered so the pulse is glitch free
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            frame_done <= 1'b0;
        end
        else
        begin
            frame_done <= frame_end;
        end
    end

    // Ready is combinational so it drops the cycle an edge is taken
    assign trigger_ready_output = trig_enabled && armed_r
        && (state_r == htac_pkg::ST_ARMED) && period_ok
        && !accept;
    assign exposure_active = (state_r == htac_pkg::ST_EXPOSE);
    assign readout_active = (state_r == htac_pkg::ST_READOUT);
    assign transmit_active = (state_r == htac_pkg::ST_TRANSMIT);
    assign armed = armed_r;
endmodule

// file: verification/htac_ctrl_sva.sv
// Checker for the trigger acquisition controller, bound to its ports.
// Assumes one clock domain and the design's own CNT_W.
`timescale 1ns/1ps
module htac_ctrl_sva #(parameter int CNT_W = 16)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic input_line_1,
    input wire logic input_line_2,
    input wire logic [1:0] trigger_selector,
    input wire logic trigger_mode_on,
    input wire logic trigger_source_line2,
    input wire logic trigger_activation_falling,
    input wire logic exposure_mode_width,
    input wire logic continuous_mode,
    input wire logic acquisition_start,
    input wire logic acquisition_stop,
    input wire logic frame_rate_limit_enable,
    input wire logic [CNT_W-1:0] frame_period_ticks,
    input wire logic [CNT_W-1:0] exposure_ticks,
    input wire logic [CNT_W-1:0] readout_ticks,
    input wire logic [CNT_W-1:0] transmit_ticks,
    input wire logic trigger_ready_output,
    input wire logic exposure_active,
    input wire logic readout_active,
    input wire logic transmit_active,
    input wire logic armed
);
    logic lvl, lvl_q, acc, one_q, stop_q, rdy_q;
    logic [CNT_W-1:0] gap;
    assign lvl = (trigger_source_line2 ? input_line_2 : input_line_1)
        ^ trigger_activation_falling;
    // Ready drops as the edge is taken, so use its value one edge before
    assign acc = rdy_q & lvl & ~lvl_q;
    // Level seen high at release so no false edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lvl_q <= 1'b1;
            rdy_q <= 1'b0;
            one_q <= 1'b0;
            stop_q <= 1'b1;
            gap <= '1;
        end
        else
        begin
            lvl_q <= lvl;
            rdy_q <= trigger_ready_output;
            one_q <= ~acquisition_start & (one_q | (acc & ~continuous_mode));
            stop_q <= acquisition_stop | (stop_q & ~acquisition_start);
            gap <= acc ? CNT_W'(1) : gap + CNT_W'(~&gap);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_exp_end;
        $fell(exposure_active) && !exposure_mode_width;
    endsequence
    AST_RDY_UNARMED: assert property (
        !armed |-> !trigger_ready_output)
        else $error("ready high while not armed");
    AST_ACCEPT: assert property (acc |=> exposure_active)
        else $error("accepted edge did not start exposure");
    AST_SEL_OFF: assert property (
        (trigger_selector != 2'h0 || !trigger_mode_on)
        |-> !trigger_ready_output)
        else $error("ready high with trigger disabled");
    AST_EXP_RD: assert property (s_exp_end |-> readout_active)
        else $error("no readout after exposure");
    AST_SINGLE: assert property (
        one_q |-> !trigger_ready_output)
        else $error("single frame ready without new start");
    AST_STOP: assert property (stop_q |-> !trigger_ready_output)
        else $error("ready high after stop");
    AST_RATE: assert property (
        frame_rate_limit_enable && trigger_ready_output
        |-> gap >= frame_period_ticks)
        else $error("ready before frame period elapsed");
    AST_BUSY: assert property (
        trigger_ready_output
        |-> !(exposure_active || readout_active || transmit_active))
        else $error("ready high during a frame");
    AST_CAP: assert property (
        trigger_ready_output |-> {2'b00, gap} >= ({2'b00, exposure_ticks}
        + readout_ticks + transmit_ticks))
        else $error("ready faster than maximum frame rate");
endmodule
bind htac_ctrl htac_ctrl_sva #(.CNT_W(CNT_W)) htac_ctrl_sva_i (.*);

// file: verification/htac_src_model.sv
// External trigger source: applies an edge only once ready is high.
// Assumes go is a one-cycle pulse given while the model is idle.
`timescale 1ns/1ps
module htac_src_model
(
    input wire logic clk,
    input wire logic ready,
    input wire logic go,
    input wire logic pol,
    input wire logic [7:0] hold,
    output logic line
);
    logic act = 1'b0;
    // Idle level follows the chosen polarity
    assign line = act ^ pol;
    initial
    forever
    begin
        @(posedge clk);
        if (go)
        begin
            @(negedge clk);
            while (!ready) @(negedge clk);
            act = 1'b1;
            repeat (hold) @(negedge clk);
            act = 1'b0;
        end
    end
endmodule

// file: verification/htac_ctrl_tb.sv
// Bench for the trigger acquisition controller with a source model.
// Assumes design, checker and source model are compiled before it.
`timescale 1ns/1ps
module htac_ctrl_tb;
    logic clk, reset_n, input_line_1, input_line_2, trigger_mode_on;
    logic trigger_source_line2, trigger_activation_falling, go, swap;
    logic exposure_mode_width, continuous_mode, acquisition_start;
    logic acquisition_stop, frame_rate_limit_enable, line_b, src_line;
    logic trigger_ready_output, exposure_active, readout_active;
    logic transmit_active, armed, frame_done;
    logic [1:0] trigger_selector;
    logic [15:0] exposure_ticks, readout_ticks, transmit_ticks;
    logic [15:0] frame_period_ticks;
    logic [7:0] hold;
    int n_errors, cmp_count, frames, n_exp, n_rt;
    assign input_line_1 = swap ? line_b : src_line;
    assign input_line_2 = swap ? src_line : line_b;
    htac_ctrl #(.TIME_BASE_CYC(1)) htac_ctrl_i (.*);
    htac_src_model htac_src_model_i (.clk(clk), .ready(trigger_ready_output),
        .go(go), .pol(trigger_activation_falling), .hold(hold),
        .line(src_line));
    always @(posedge clk)
    begin
        frames += (frame_done === 1'b1);
        n_exp += (exposure_active === 1'b1);
        n_rt += (readout_active === 1'b1 || transmit_active === 1'b1);
    end
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic wrap_up();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic start();
        @(negedge clk) acquisition_start = 1'b1;
        @(negedge clk) acquisition_start = 1'b0;
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        while (frame_done !== 1'b1 && k < 500)
        begin
            @(negedge clk);
            k++;
        end
        chk(16'(k < 500), 16'h1);
        @(negedge clk);
    endtask
    task automatic frame();
        @(negedge clk) go = 1'b1;
        @(negedge clk) go = 1'b0;
        wait_done();
    endtask
    initial
    begin
        {reset_n, trigger_source_line2, trigger_activation_falling, go} = '0;
        {swap, exposure_mode_width, continuous_mode, acquisition_start} = '0;
        {acquisition_stop, frame_rate_limit_enable, line_b} = '0;
        {n_errors, cmp_count, frames, n_exp, n_rt} = '0;
        trigger_mode_on = 1'b1;
        trigger_selector = 2'h1;
        exposure_ticks = 16'h3;
        readout_ticks = 16'h2;
        transmit_ticks = 16'h2;
        frame_period_ticks = 16'h1e;
        hold = 8'h1;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        start();
        repeat (3) @(negedge clk);
        chk(trigger_ready_output, 16'h0);
        trigger_selector = 2'h0;
        trigger_mode_on = 1'b0;
        repeat (3) @(negedge clk);
        chk(trigger_ready_output, 16'h0);
        trigger_mode_on = 1'b1;
        // Default source line 1, rising, timed, single frame
        start();
        {n_exp, n_rt} = '0;
        frame();
        chk(16'(frames), 16'h1);
        chk(16'(n_exp), exposure_ticks);
        chk(16'(n_rt), readout_ticks + transmit_ticks);
        @(negedge clk) go = 1'b1;
        @(negedge clk) go = 1'b0;
        repeat (40) @(negedge clk);
        chk(16'(frames), 16'h1);
        chk(trigger_ready_output, 16'h0);
        start();
        wait_done();
        chk(16'(frames), 16'h2);
        // Edge on the unselected line must not count
        trigger_source_line2 = 1'b1;
        swap = 1'b1;
        start();
        repeat (3) @(negedge clk) line_b = ~line_b;
        repeat (3) @(negedge clk);
        chk(16'(frames), 16'h2);
        chk(trigger_ready_output, 16'h1);
        frame();
        chk(16'(frames), 16'h3);
        trigger_activation_falling = 1'b1;
        line_b = 1'b1;
        start();
        frame();
        chk(16'(frames), 16'h4);
        continuous_mode = 1'b1;
        frame_rate_limit_enable = 1'b1;
        repeat (40) @(negedge clk);
        start();
        repeat (3) frame();
        chk(16'(frames), 16'h7);
        frame_period_ticks = 16'h1;
        repeat (2) frame();
        chk(16'(frames), 16'h9);
        exposure_mode_width = 1'b1;
        hold = 8'h14;
        n_exp = 0;
        frame();
        chk(16'(n_exp inside {[19:22]}), 16'h1);
        @(negedge clk) acquisition_stop = 1'b1;
        @(negedge clk) acquisition_stop = 1'b0;
        repeat (20) @(negedge clk);
        chk(trigger_ready_output, 16'h0);
        wrap_up();
    end
    initial
    begin
        #300us;
        n_errors++;
        wrap_up();
    end
endmodule
